// ===== design/ccb_consts.vh
// Constants for the cross-core mailbox bridge
`ifndef CCB_CONSTS_VH
`define CCB_CONSTS_VH
// ----------------------------------------------------------------------
// Primary register word offsets
// ----------------------------------------------------------------------
`define CCB_OFS_CON     5'h00
`define CCB_OFS_STAT    5'h01
`define CCB_OFS_KEY     5'h02
`define CCB_OFS_MBXS    5'h03
`define CCB_OFS_FCS     5'h04
`define CCB_OFS_RFDATA  5'h05
`define CCB_OFS_WFDATA  5'h06
// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define CCB_CON_SEN     15
`define CCB_CON_P2S     9
`define CCB_CON_ACK     8
`define CCB_CON_SRIE    7
`define CCB_FCS_WFEN    15
`define CCB_FCS_WFOF    11
`define CCB_FCS_WFUF    10
`define CCB_FCS_RFEN    7
`define CCB_FCS_RFOF    3
`define CCB_FCS_RFUF    2
`define CCB_SEC_DATA0   0
// ----------------------------------------------------------------------
// Reset values and key sequence
// ----------------------------------------------------------------------
`define CCB_RST_WORD    16'h0000
`define CCB_KEY_FIRST   8'h55
`define CCB_KEY_SECOND  8'hAA
// ----------------------------------------------------------------------
// FIFO geometry and thresholds
// ----------------------------------------------------------------------
`define CCB_FIFO_DEPTH  32
`define CCB_FIFO_AW     5
`define CCB_FIFO_FULL   6'h20
`define CCB_THR_FIRST   6'h01
`define CCB_THR_HALF    6'h10
`define CCB_THR_3Q      6'h18
// ----------------------------------------------------------------------
// Secondary link operations
// ----------------------------------------------------------------------
`define CCB_SOP_MBW     3'h0
`define CCB_SOP_MBR     3'h1
`define CCB_SOP_RFW     3'h2
`define CCB_SOP_WFR     3'h3
`define CCB_SOP_IRQ     3'h4
`define CCB_SOP_STS     3'h5
`define CCB_SOP_ACK     3'h6
`define CCB_SOP_CLR     3'h7
`endif

// ===== design/ccb_sync.v
// Three-stage synchroniser for inputs from the secondary domain
`timescale 1ns/1ns
module ccb_sync #(
  parameter W = 1
) (
  // Clock, reset, enable
  input  wire         mclk,
  input  wire         srst,
  input  wire         ce,
  // Asynchronous input and late stages
  input  wire [W-1:0] din,
  output reg  [W-1:0] q2_r,
  output reg  [W-1:0] q3_r
);

  reg [W-1:0] q1_r;

  always @(posedge mclk) begin
    if (srst) begin
      q1_r <= {W{1'b0}};
      q2_r <= {W{1'b0}};
      q3_r <= {W{1'b0}};
    end else if (ce) begin
      q1_r <= din;
      q2_r <= q1_r;
      q3_r <= q2_r;
    end
  end

endmodule

// ===== design/ccb_mem.v
// FIFO storage with registered read data
`timescale 1ns/1ns
`include "ccb_consts.vh"
module ccb_mem (
  // Clock and enable
  input  wire                    mclk,
  input  wire                    ce,
  // Write side
  input  wire                    wr_en,
  input  wire [`CCB_FIFO_AW-1:0] wr_addr,
  input  wire [15:0]             wr_data,
  // Read side
  input  wire                    rd_en,
  input  wire [`CCB_FIFO_AW-1:0] rd_addr,
  output reg  [15:0]             rd_data_r
);

  reg [15:0] mem [0:`CCB_FIFO_DEPTH-1];

  always @(posedge mclk) begin
    if (ce) begin
      if (wr_en) begin
        mem[wr_addr] <= wr_data;
      end
      if (rd_en) begin
        rd_data_r <= mem[rd_addr];
      end
    end
  end

endmodule

// ===== design/ccb_bridge.v
// Cross-core mailbox bridge: primary registers and secondary link
`timescale 1ns/1ns
`include "ccb_consts.vh"
// Operation
// R1: Both core domains joined, crossings made safe
// R2: Separate register views for each core
// R3: Sixteen one-way mailbox data registers
// R4: Fuse sets direction; byte and word access
// R5: Eight handshake blocks, each fuse enabled
// R6: Writer starts transfer; reader just reads
// R7: Fuse maps each handshake block to mailbox
// R8: Ready flags raise interrupts or are polled
// R9: Read and write FIFO, depth 16 to 32
// R10: Circular FIFOs report empty and full
// R11: Overflow and underflow interrupt both cores
// R12: Each core reads both cores' mode status; here each core reads only the other core's mode status
// R13: Secondary reset can interrupt the primary
// R14: Primary reset interrupts the secondary
// R15: Power-on reset resets both; decouple by fuse
// R16: Fuse decides if resets clear secondary enable
// R17: Secondary enable writable only after key
// R18: Enable releases secondary; zero holds reset
// R19: Threshold field picks read-FIFO fill interrupt
// R20: Bit 9 requests interrupt to secondary
// R21: Bit 8 acknowledges; spurious ack is error
// R22: Bit 7 gates secondary-reset event interrupt
// R23: Write-only key watched for value sequence
// R24: Transmitter write sets ready; disabled reads zero
// R25: Primary writes to inbound mailboxes ignored
// R26: Reset flag follows secondary; edge fires event
// R27: Crossing signals pass synchronisers or handshake
// R28: Control bits clear to zero on reset
module ccb_bridge (
  // Clock, reset, enable
  input  wire        mclk,
  input  wire        srst,
  input  wire        ce,
  // Primary register port
  input  wire [4:0]  pri_addr,
  input  wire        pri_wr,
  input  wire        pri_rd,
  input  wire [1:0]  pri_be,
  input  wire [15:0] pri_wdata,
  output reg  [15:0] pri_rdata_r,
  output reg         pri_rvalid_r,
  // Primary status and run-time reset
  input  wire        pri_runtime_rst,
  input  wire [2:0]  pri_mode,
  // Configuration fuses
  input  wire [15:0] mailbox_direction_fuse,
  input  wire [7:0]  hs_en_fuse,
  input  wire [31:0] hs_map_fuse,
  input  wire        rst_decouple_fuse,
  input  wire        rst_clr_en_fuse,
  // Secondary link, asynchronous
  input  wire        sec_req_tgl,
  input  wire [2:0]  sec_op,
  input  wire [3:0]  sec_idx,
  input  wire [15:0] sec_wdata,
  input  wire        sec_in_reset,
  input  wire        sec_wdt_rst,
  input  wire [1:0]  sec_pwr,
  input  wire        sec_dbg,
  output reg         sec_ack_tgl_r,
  output reg  [15:0] sec_rdata_r,
  // Towards the secondary core
  output reg         sec_hold_reset_r,
  output reg         primary_to_secondary_irq_req,
  output reg         secondary_irq_acknowledge,
  output reg         pri_reset_evt_r,
  output reg         sec_mbx_irq_r,
  output reg         sec_wf_irq_r,
  output reg         sec_fifo_err_r,
  // Towards the primary core
  output reg         pri_mbx_irq_r,
  output reg         pri_fifo_irq_r,
  output reg         pri_fifo_err_r,
  output reg         pri_srst_irq_r,
  output reg         pri_s2p_irq_r,
  output reg         proto_err_r
);

  localparam KEY_IDLE  = 2'h0;
  localparam KEY_ONE   = 2'h1;
  localparam KEY_ARMED = 2'h2;

  // --------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------
  reg  [15:0] mbx_r [0:15];
  reg  [7:0]  mailbox_data_ready, mailbox_data_ready_nxt, rx_pri, rx_sec;
  reg         secondary_enable, secondary_reset_irq_enable;
  reg  [1:0]  read_fifo_irq_threshold, key_st_r;
  reg         secondary_to_primary_irq_req, sack_r, sflag_prev_r;
  reg  [4:0]  sts_r;
  reg         req_seen_r, s_stage_r, rd_pend_r;
  reg  [2:0]  s_op_r;
  reg  [3:0]  s_idx_r, hs_m;
  reg  [4:0]  rd_addr_r;
  reg         wfen_r, rfen_r, wfof_r, wfuf_r, rfof_r, rfuf_r;
  reg  [4:0]  wf_wp_r, wf_rp_r, rf_wp_r, rf_rp_r;
  reg  [5:0]  wf_cnt_r, rf_cnt_r, thr;
  reg         hs_set, hs_clr, hs_old;
  reg  [15:0] rd_mux, s_mux;
  wire [15:0] wf_dout, rf_dout;
  wire        req_q2, req_q3;
  wire [4:0]  sts_q2, sts_q3;
  integer     i;

  // --------------------------------------------------------------------
  // Crossing from the secondary domain
  // --------------------------------------------------------------------
  ccb_sync #(.W(1)) u_req_sync (
    .mclk (mclk),
    .srst (srst),
    .ce   (ce),
    .din  (sec_req_tgl),
    .q2_r (req_q2),
    .q3_r (req_q3)
  ); // R27
  ccb_sync #(.W(5)) u_sts_sync (
    .mclk (mclk),
    .srst (srst),
    .ce   (ce),
    .din  ({sec_in_reset, sec_wdt_rst, sec_pwr, sec_dbg}),
    .q2_r (sts_q2),
    .q3_r (sts_q3)
  ); // R1

  // Request counts once stages two and three agree
  wire req_go = ce & (req_q2 == req_q3) & (req_q3 != req_seen_r); // R1
  wire s_mbw  = req_go & (sec_op == `CCB_SOP_MBW);
  wire s_mbr  = req_go & (sec_op == `CCB_SOP_MBR);
  wire s_rfw  = req_go & (sec_op == `CCB_SOP_RFW);
  wire s_wfr  = req_go & (sec_op == `CCB_SOP_WFR);
  wire s_irq  = req_go & (sec_op == `CCB_SOP_IRQ);
  wire s_ack  = req_go & (sec_op == `CCB_SOP_ACK);
  wire s_clr  = req_go & (sec_op == `CCB_SOP_CLR);

  // --------------------------------------------------------------------
  // Primary decode
  // --------------------------------------------------------------------
  wire       pw     = ce & pri_wr; // R2
  wire       pr     = ce & pri_rd;
  wire [3:0] pidx   = pri_addr[3:0];
  wire       con_wr = pw & (pri_addr == `CCB_OFS_CON);
  wire       key_wr = pw & (pri_addr == `CCB_OFS_KEY) & pri_be[0];
  wire       fcs_wr = pw & (pri_addr == `CCB_OFS_FCS);
  wire       mbs_wr = pw & (pri_addr == `CCB_OFS_MBXS) & pri_be[0];
  wire p_mbx_wr = pw & pri_addr[4] & ~mailbox_direction_fuse[pidx]; // R25
  wire p_mbx_rd = pr & pri_addr[4] & mailbox_direction_fuse[pidx];
  wire s_mbx_wr = s_mbw & mailbox_direction_fuse[sec_idx]; // R3
  wire s_mbx_rd = s_mbr & ~mailbox_direction_fuse[sec_idx];
  wire sflag    = sts_r[4] | sec_hold_reset_r; // R26

  // --------------------------------------------------------------------
  // FIFO channels
  // --------------------------------------------------------------------
  wire       wf_full  = (wf_cnt_r == `CCB_FIFO_FULL);
  wire       wf_empty = (wf_cnt_r == 6'h00);
  wire       rf_full  = (rf_cnt_r == `CCB_FIFO_FULL);
  wire       rf_empty = (rf_cnt_r == 6'h00);
  wire p_wf_wr = pw & (pri_addr == `CCB_OFS_WFDATA) & wfen_r;
  wire p_rf_rd = pr & (pri_addr == `CCB_OFS_RFDATA) & rfen_r;
  wire wf_push = p_wf_wr & ~wf_full;
  wire wf_of   = p_wf_wr & wf_full; // R11
  wire wf_pop  = s_wfr & wfen_r & ~wf_empty;
  wire wf_uf   = s_wfr & wfen_r & wf_empty; // R11
  wire rf_push = s_rfw & rfen_r & ~rf_full;
  wire rf_of   = s_rfw & rfen_r & rf_full; // R11
  wire rf_pop  = p_rf_rd & ~rf_empty;
  wire rf_uf   = p_rf_rd & rf_empty; // R11
  wire [5:0] rf_cnt_nxt = rf_cnt_r + {5'h00, rf_push} - {5'h00, rf_pop};
  wire [5:0] wf_cnt_nxt = wf_cnt_r + {5'h00, wf_push} - {5'h00, wf_pop};

  ccb_mem u_wf_mem (
    .mclk      (mclk),
    .ce        (ce),
    .wr_en     (wf_push),
    .wr_addr   (wf_wp_r),
    .wr_data   (pri_wdata),
    .rd_en     (wf_pop),
    .rd_addr   (wf_rp_r),
    .rd_data_r (wf_dout)
  ); // R9
  ccb_mem u_rf_mem (
    .mclk      (mclk),
    .ce        (ce),
    .wr_en     (rf_push),
    .wr_addr   (rf_wp_r),
    .wr_data   (sec_wdata),
    .rd_en     (rf_pop),
    .rd_addr   (rf_rp_r),
    .rd_data_r (rf_dout)
  ); // R9

  // --------------------------------------------------------------------
  // Handshake blocks and threshold
  // --------------------------------------------------------------------
  always @* begin
    hs_m   = 4'h0;
    hs_set = 1'b0;
    hs_clr = 1'b0;
    hs_old = 1'b0;
    for (i = 0; i < 8; i = i + 1) begin
      hs_m   = hs_map_fuse[4*i +: 4]; // R7
      hs_set = (p_mbx_wr & (pidx == hs_m)) | (s_mbx_wr & (sec_idx == hs_m));
      hs_clr = (p_mbx_rd & (pidx == hs_m)) | (s_mbx_rd & (sec_idx == hs_m));
      hs_old = mbs_wr ? pri_wdata[i] : mailbox_data_ready[i];
      mailbox_data_ready_nxt[i] = hs_en_fuse[i] & (hs_set | (hs_old & ~hs_clr)); // R24 R5
      rx_pri[i] = mailbox_data_ready[i] & mailbox_direction_fuse[hs_m];
      rx_sec[i] = mailbox_data_ready[i] & ~mailbox_direction_fuse[hs_m];
    end
    case (read_fifo_irq_threshold)
      2'h0:    thr = `CCB_THR_FIRST;
      2'h1:    thr = `CCB_THR_HALF;
      2'h2:    thr = `CCB_THR_3Q;
      default: thr = `CCB_FIFO_FULL;
    endcase
  end

  // --------------------------------------------------------------------
  // Read multiplexers
  // --------------------------------------------------------------------
  always @* begin
    case (rd_addr_r)
      `CCB_OFS_CON:    rd_mux = {secondary_enable, 3'h0,
                                 read_fifo_irq_threshold,
                                 primary_to_secondary_irq_req,
                                 secondary_irq_acknowledge,
                                 secondary_reset_irq_enable, 7'h00};
      `CCB_OFS_STAT:   rd_mux = {sflag, sts_r[3:1], 2'h0,
                                 secondary_to_primary_irq_req, sack_r,
                                 sts_r[0], 7'h00}; // R12
      `CCB_OFS_MBXS:   rd_mux = {8'h00, mailbox_data_ready};
      `CCB_OFS_FCS:    rd_mux = {wfen_r, 3'h0, wfof_r, wfuf_r, wf_full,
                                 wf_empty, rfen_r, 3'h0, rfof_r, rfuf_r,
                                 rf_full, rf_empty}; // R10
      `CCB_OFS_RFDATA: rd_mux = rf_dout;
      default:         rd_mux = rd_addr_r[4] ? mbx_r[rd_addr_r[3:0]]
                                             : `CCB_RST_WORD;
    endcase
    case (s_op_r)
      `CCB_SOP_MBR: s_mux = mbx_r[s_idx_r];
      `CCB_SOP_WFR: s_mux = wf_dout;
      `CCB_SOP_STS: s_mux = {pri_mode, primary_to_secondary_irq_req,
                             secondary_irq_acknowledge, 3'h0,
                             mailbox_data_ready}; // R12
      default:      s_mux = `CCB_RST_WORD;
    endcase
  end

  // --------------------------------------------------------------------
  // Mailbox storage
  // --------------------------------------------------------------------
  always @(posedge mclk) begin
    if (srst) begin
      for (i = 0; i < 16; i = i + 1) begin
        mbx_r[i] <= `CCB_RST_WORD;
      end
    end else begin
      if (p_mbx_wr & pri_be[1]) begin
        mbx_r[pidx][15:8] <= pri_wdata[15:8]; // R4
      end
      if (p_mbx_wr & pri_be[0]) begin
        mbx_r[pidx][7:0] <= pri_wdata[7:0]; // R4
      end
      if (s_mbx_wr) begin
        mbx_r[sec_idx] <= sec_wdata;
      end
    end
  end

  // --------------------------------------------------------------------
  // Control, FIFO pointers, flags and answers
  // --------------------------------------------------------------------
  always @(posedge mclk) begin
    if (srst) begin
      secondary_enable             <= 1'b0; // R28
      read_fifo_irq_threshold      <= 2'h0;
      primary_to_secondary_irq_req <= 1'b0;
      secondary_irq_acknowledge    <= 1'b0;
      secondary_reset_irq_enable   <= 1'b0;
      key_st_r                     <= KEY_IDLE;
      mailbox_data_ready           <= 8'h00;
      secondary_to_primary_irq_req <= 1'b0;
      sack_r                       <= 1'b0;
      sflag_prev_r                 <= 1'b1;
      sts_r                        <= 5'h00;
      req_seen_r                   <= 1'b0;
      s_stage_r                    <= 1'b0;
      s_op_r                       <= 3'h0;
      s_idx_r                      <= 4'h0;
      rd_pend_r                    <= 1'b0;
      rd_addr_r                    <= 5'h00;
      {wfen_r, rfen_r, wfof_r, wfuf_r, rfof_r, rfuf_r} <= 6'h00;
      {wf_wp_r, wf_rp_r, rf_wp_r, rf_rp_r} <= 20'h00000;
      {wf_cnt_r, rf_cnt_r}         <= 12'h000;
      pri_rdata_r                  <= `CCB_RST_WORD;
      pri_rvalid_r                 <= 1'b0;
      sec_ack_tgl_r                <= 1'b0;
      sec_rdata_r                  <= `CCB_RST_WORD;
      sec_hold_reset_r             <= 1'b1; // R15
      pri_reset_evt_r              <= 1'b0;
      {sec_mbx_irq_r, sec_wf_irq_r, sec_fifo_err_r} <= 3'h0;
      {pri_mbx_irq_r, pri_fifo_irq_r, pri_fifo_err_r} <= 3'h0;
      {pri_srst_irq_r, pri_s2p_irq_r, proto_err_r} <= 3'h0;
    end else if (ce) begin
      // Key sequencer and control register
      if (con_wr & pri_be[1]) begin
        key_st_r <= KEY_IDLE;
        if (key_st_r == KEY_ARMED) begin
          secondary_enable <= pri_wdata[`CCB_CON_SEN]; // R17
        end
        read_fifo_irq_threshold      <= pri_wdata[11:10];
        primary_to_secondary_irq_req <= pri_wdata[`CCB_CON_P2S]; // R20
        secondary_irq_acknowledge    <= pri_wdata[`CCB_CON_ACK]; // R21
      end else if (key_wr) begin
        case (key_st_r)
          KEY_IDLE: key_st_r <= (pri_wdata[7:0] == `CCB_KEY_FIRST) ?
                                KEY_ONE : KEY_IDLE; // R23
          KEY_ONE:  key_st_r <= (pri_wdata[7:0] == `CCB_KEY_SECOND) ?
                                KEY_ARMED : KEY_IDLE; // R23
          default:  key_st_r <= KEY_IDLE;
        endcase
      end
      if (con_wr & pri_be[0]) begin
        secondary_reset_irq_enable <= pri_wdata[`CCB_CON_SRIE]; // R22
      end
      if (pri_runtime_rst & rst_clr_en_fuse) begin
        secondary_enable <= 1'b0; // R16
        key_st_r         <= KEY_IDLE;
      end
      sec_hold_reset_r <= ~secondary_enable |
                          (pri_runtime_rst & ~rst_decouple_fuse); // R18
      // Handshake flags and cross-core requests
      mailbox_data_ready <= mailbox_data_ready_nxt; // R24
      if (s_irq) begin
        secondary_to_primary_irq_req <= sec_wdata[`CCB_SEC_DATA0];
      end
      sack_r <= primary_to_secondary_irq_req & (sack_r | s_ack);
      proto_err_r <= (s_ack & ~primary_to_secondary_irq_req) |
                     (con_wr & pri_be[1] & pri_wdata[`CCB_CON_ACK] &
                      ~secondary_to_primary_irq_req); // R21
      pri_reset_evt_r <= (pri_runtime_rst & ~sflag) |
                         (pri_reset_evt_r & ~s_clr); // R14
      // Secondary status and reset event
      if (sts_q2 == sts_q3) begin
        sts_r <= sts_q3; // R27
      end
      sflag_prev_r   <= sflag;
      pri_srst_irq_r <= secondary_reset_irq_enable & sflag &
                        ~sflag_prev_r; // R13
      // Write FIFO, primary to secondary
      if (!wfen_r) begin
        {wf_wp_r, wf_rp_r, wf_cnt_r} <= 16'h0000;
      end else begin
        wf_wp_r  <= wf_wp_r + {4'h0, wf_push}; // R10
        wf_rp_r  <= wf_rp_r + {4'h0, wf_pop};
        wf_cnt_r <= wf_cnt_nxt;
      end
      // Read FIFO, secondary to primary
      if (!rfen_r) begin
        {rf_wp_r, rf_rp_r, rf_cnt_r} <= 16'h0000;
      end else begin
        rf_wp_r  <= rf_wp_r + {4'h0, rf_push}; // R10
        rf_rp_r  <= rf_rp_r + {4'h0, rf_pop};
        rf_cnt_r <= rf_cnt_nxt;
      end
      pri_fifo_irq_r <= rf_push & (rf_cnt_nxt == thr); // R19
      if (fcs_wr & pri_be[1]) begin
        wfen_r <= pri_wdata[`CCB_FCS_WFEN];
      end
      if (fcs_wr & pri_be[0]) begin
        rfen_r <= pri_wdata[`CCB_FCS_RFEN];
      end
      wfof_r <= wf_of | (wfof_r &
                ~(fcs_wr & pri_be[1] & ~pri_wdata[`CCB_FCS_WFOF]));
      wfuf_r <= wf_uf | (wfuf_r &
                ~(fcs_wr & pri_be[1] & ~pri_wdata[`CCB_FCS_WFUF]));
      rfof_r <= rf_of | (rfof_r &
                ~(fcs_wr & pri_be[0] & ~pri_wdata[`CCB_FCS_RFOF]));
      rfuf_r <= rf_uf | (rfuf_r &
                ~(fcs_wr & pri_be[0] & ~pri_wdata[`CCB_FCS_RFUF]));
      pri_fifo_err_r <= wfof_r | wfuf_r | rfof_r | rfuf_r; // R11
      sec_fifo_err_r <= wfof_r | wfuf_r | rfof_r | rfuf_r; // R11
      sec_wf_irq_r   <= ~wf_empty;
      // Interrupt levels
      pri_mbx_irq_r <= |rx_pri; // R8
      sec_mbx_irq_r <= |rx_sec; // R8
      pri_s2p_irq_r <= secondary_to_primary_irq_req;
      // Primary read answer, two cycles after the request
      rd_pend_r    <= pr;
      rd_addr_r    <= pri_addr;
      pri_rvalid_r <= rd_pend_r;
      if (rd_pend_r) begin
        pri_rdata_r <= rd_mux;
      end
      // Secondary answer by toggle handshake
      if (req_go) begin
        req_seen_r <= req_q3; // R6
      end
      s_stage_r <= req_go;
      s_op_r    <= sec_op;
      s_idx_r   <= sec_idx;
      if (s_stage_r) begin
        sec_rdata_r   <= s_mux;
        sec_ack_tgl_r <= ~sec_ack_tgl_r; // R27
      end
    end
  end

endmodule

// ===== bench/ccb_sec_model.sv
// Secondary core model at the far side
`timescale 1ns/1ns
module ccb_sec_model (
  // Clock and answers
  input  wire        mclk,
  input  wire        hold,
  input  wire        ack,
  input  wire [15:0] rdata,
  // Request and status lines
  output logic       req,
  output logic [2:0] op,
  output logic [3:0] idx,
  output logic [15:0] wdata,
  output logic       in_rst,
  output logic       wdt,
  output logic [1:0] pwr,
  output logic       dbg
);
  initial begin
    {req, op, idx, wdata, wdt} = 24'h0;
    {in_rst, pwr, dbg} = 4'hD;
  end
  // Core leaves reset after release
  always @(hold) in_rst <= #30 hold;
  task automatic xfer(input [2:0] o, input [3:0] i, input [15:0] d,
                      output [15:0] q);
    logic a;
    int   n;
    a = ack;
    n = 0;
    @(negedge mclk);
    op = o;
    idx = i;
    wdata = d;
    @(negedge mclk);
    req = ~req;
    while (ack === a && n < 40) begin
      @(posedge mclk);
      n++;
    end
    q = rdata;
    wdata = ~d;
  endtask
endmodule

// ===== bench/ccb_bridge_asserts.sv
// Bridge port assertions
`timescale 1ns/1ns
`include "ccb_consts.vh"
module ccb_bridge_asserts (
  input wire        mclk,
  input wire        srst,
  input wire        ce,
  input wire [4:0]  pri_addr,
  input wire        pri_wr,
  input wire        pri_rd,
  input wire [1:0]  pri_be,
  input wire [15:0] pri_wdata,
  input wire [15:0] pri_rdata_r,
  input wire        pri_rvalid_r,
  input wire        sec_req_tgl,
  input wire        sec_ack_tgl_r,
  input wire        primary_to_secondary_irq_req,
  input wire        secondary_irq_acknowledge,
  input wire        pri_srst_irq_r,
  input wire        pri_fifo_err_r,
  input wire        sec_fifo_err_r
);
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  wire con_hi = ce && pri_wr && pri_addr == `CCB_OFS_CON && pri_be[1];
  rd_latency_a: assert property ((ce && pri_rd) |-> ##2 pri_rvalid_r)
    else $error("read answer late");
  rdata_hold_a: assert property ($changed(pri_rdata_r) |-> pri_rvalid_r)
    else $error("read data moved");
  p2s_level_a: assert property (con_hi |=>
    primary_to_secondary_irq_req == $past(pri_wdata[`CCB_CON_P2S]))
    else $error("request bit");
  ack_level_a: assert property (con_hi |=>
    secondary_irq_acknowledge == $past(pri_wdata[`CCB_CON_ACK]))
    else $error("ack bit");
  srst_pulse_a: assert property (pri_srst_irq_r |=> !pri_srst_irq_r)
    else $error("reset event long");
  link_answer_a: assert property ($changed(sec_req_tgl) |->
    ##[3:9] $changed(sec_ack_tgl_r))
    else $error("link answer late");
  link_single_a: assert property ($changed(sec_ack_tgl_r) |=>
    $stable(sec_ack_tgl_r) [*3])
    else $error("link ack repeated");
  fifo_err_both_a: assert property (pri_fifo_err_r == sec_fifo_err_r)
    else $error("fifo error views");
  cover property (pri_rvalid_r);
  cover property (pri_srst_irq_r);
  cover property ($changed(sec_ack_tgl_r));
endmodule
bind ccb_bridge ccb_bridge_asserts chk_u (.mclk, .srst, .ce, .pri_addr,
  .pri_wr, .pri_rd, .pri_be, .pri_wdata, .pri_rdata_r, .pri_rvalid_r,
  .sec_req_tgl, .sec_ack_tgl_r, .primary_to_secondary_irq_req,
  .secondary_irq_acknowledge, .pri_srst_irq_r, .pri_fifo_err_r,
  .sec_fifo_err_r);

// ===== bench/test_dual_core_mailbox_bridge.sv
// Self-checking bench for the bridge
`timescale 1ns/1ns
module test_dual_core_mailbox_bridge;
  logic mclk = 0, srst = 1, pri_wr = 0, pri_rd = 0, pri_runtime_rst = 0;
  logic [4:0]  pri_addr = 5'h0;
  logic [1:0]  pri_be = 2'h0;
  logic [15:0] pri_wdata = 16'h0, q, dirf, mb [16];
  logic [31:0] s = 32'h4EB3BDCF;
  logic [2:0]  pri_mode;
  int err_total = 0, num_checks = 0, cyc = 0, perr = 0, nsr = 0, nfi = 0;
  logic [15:0] fq [$];
  wire sec_req_tgl, sec_in_reset, sec_wdt_rst, sec_dbg, sec_ack_tgl_r;
  wire sec_hold_reset_r, primary_to_secondary_irq_req, pri_mbx_irq_r;
  wire secondary_irq_acknowledge, pri_reset_evt_r, pri_fifo_irq_r;
  wire pri_fifo_err_r, pri_srst_irq_r, pri_s2p_irq_r, proto_err_r;
  wire pri_rvalid_r;
  wire [2:0]  sec_op;
  wire [3:0]  sec_idx;
  wire [1:0]  sec_pwr;
  wire [15:0] sec_wdata, sec_rdata_r, pri_rdata_r;
  function [31:0] nx(input [31:0] v);
    nx = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  initial begin
    dirf = (s[15:0] | 16'h0100) & 16'hFFFE;
    pri_mode = s[18:16];
  end
  always #10 mclk = ~mclk;
  ccb_bridge dut_u (.mclk, .srst, .ce(1'b1), .pri_addr, .pri_wr, .pri_rd,
    .pri_be, .pri_wdata, .pri_rdata_r, .pri_rvalid_r, .pri_runtime_rst,
    .pri_mode, .mailbox_direction_fuse(dirf), .hs_en_fuse(8'h03),
    .hs_map_fuse(32'h80), .rst_decouple_fuse(1'b1),
    .rst_clr_en_fuse(1'b1), .sec_req_tgl, .sec_op, .sec_idx, .sec_wdata,
    .sec_in_reset, .sec_wdt_rst, .sec_pwr, .sec_dbg, .sec_ack_tgl_r,
    .sec_rdata_r, .sec_hold_reset_r, .primary_to_secondary_irq_req,
    .secondary_irq_acknowledge, .pri_reset_evt_r, .sec_mbx_irq_r(),
    .sec_wf_irq_r(), .sec_fifo_err_r(), .pri_mbx_irq_r, .pri_fifo_irq_r,
    .pri_fifo_err_r, .pri_srst_irq_r, .pri_s2p_irq_r, .proto_err_r);
  ccb_sec_model sec_u (.mclk, .hold(sec_hold_reset_r), .ack(sec_ack_tgl_r),
    .rdata(sec_rdata_r), .req(sec_req_tgl), .op(sec_op), .idx(sec_idx),
    .wdata(sec_wdata), .in_rst(sec_in_reset), .wdt(sec_wdt_rst),
    .pwr(sec_pwr), .dbg(sec_dbg));
  task results;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task chk(input string n, input [15:0] v, input [15:0] e);
    num_checks++;
    if (v !== e) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", n, e, v);
    end
  endtask
  task wr(input [4:0] a, input [1:0] b, input [15:0] d);
    @(negedge mclk);
    {pri_addr, pri_be, pri_wdata, pri_wr} = {a, b, d, 1'b1};
    @(negedge mclk);
    pri_wr = 0;
  endtask
  task rd(input [4:0] a, output [15:0] v);
    @(negedge mclk);
    {pri_addr, pri_rd} = {a, 1'b1};
    @(negedge mclk);
    pri_rd = 0;
    repeat (2) @(posedge mclk);
    #1 v = pri_rdata_r;
  endtask
  task wt(input int n);
    repeat (n) @(posedge mclk);
  endtask
  always @(posedge mclk) begin
    cyc++;
    perr += (proto_err_r === 1'b1);
    nsr += (pri_srst_irq_r === 1'b1);
    nfi += (pri_fifo_irq_r === 1'b1);
    if (cyc == 20000) begin
      err_total++;
      results;
    end
  end
  initial begin
    wt(12);
    @(negedge mclk) srst = 0;
    rd(5'h0, q); chk("con", q, 16'h0);
    rd(5'h2, q); chk("key", q, 16'h0);
    rd(5'h7, q); chk("unmapped", q, 16'h0);
    wr(5'h0, 2'h3, 16'h8000);
    rd(5'h0, q); chk("con", q, 16'h0);
    wr(5'h2, 2'h1, 16'h0055);
    wr(5'h2, 2'h1, 16'h00AA);
    wr(5'h0, 2'h3, 16'h8080);
    rd(5'h0, q); chk("con", q, 16'h8080);
    wt(12);
    rd(5'h1, q); chk("stat", q, 16'h2080);
    $display("key done");
    for (int i = 0; i < 16; i++) begin
      s = nx(s);
      wr(5'(16 + i), 2'h3, s[15:0]);
      mb[i] = dirf[i] ? 16'h0 : s[15:0];
    end
    wr(5'h10, 2'h1, 16'hFFFF);
    mb[0][7:0] = 8'hFF;
    for (int i = 0; i < 16; i++) begin
      rd(5'(16 + i), q); chk("mbx", q, mb[i]);
    end
    rd(5'h3, q); chk("ready", q, 16'h1);
    sec_u.xfer(3'h1, 4'h0, 16'h0, q); chk("sec read", q, mb[0]);
    s = nx(s);
    sec_u.xfer(3'h0, 4'h8, s[15:0], q);
    wt(4);
    rd(5'h3, q); chk("ready", q, 16'h2);
    chk("mbx irq", {15'h0, pri_mbx_irq_r}, 16'h1);
    rd(5'h18, q); chk("mbx", q, s[15:0]);
    rd(5'h3, q); chk("ready", q, 16'h0);
    $display("mailbox done");
    wr(5'h0, 2'h2, 16'h0280);
    chk("p2s", {15'h0, primary_to_secondary_irq_req}, 16'h1);
    sec_u.xfer(3'h6, 4'h0, 16'h0, q);
    sec_u.xfer(3'h4, 4'h0, 16'h1, q);
    wt(6);
    rd(5'h1, q); chk("stat", q, 16'h2380);
    chk("s2p irq", {15'h0, pri_s2p_irq_r}, 16'h1);
    wr(5'h0, 2'h2, 16'h0380);
    sec_u.xfer(3'h5, 4'h0, 16'h0, q);
    chk("sec stat", q, {pri_mode, 13'h1800});
    sec_u.xfer(3'h4, 4'h0, 16'h0, q);
    wt(6);
    wr(5'h0, 2'h2, 16'h0);
    perr = 0;
    wr(5'h0, 2'h2, 16'h0100);
    wt(3);
    chk("proto err", perr[15:0], 16'h1);
    nsr = 0;
    @(negedge mclk) pri_runtime_rst = 1;
    @(negedge mclk) pri_runtime_rst = 0;
    wt(15);
    chk("srst irq", nsr[15:0], 16'h1);
    chk("reset evt", {15'h0, pri_reset_evt_r}, 16'h1);
    $display("irq done");
    wr(5'h0, 2'h2, 16'h0400);
    wr(5'h4, 2'h3, 16'h0080);
    nfi = 0;
    for (int i = 0; i < 16; i++) begin
      s = nx(s);
      fq.push_back(s[15:0]);
      sec_u.xfer(3'h2, 4'h0, s[15:0], q);
    end
    chk("fifo irq", nfi[15:0], 16'h1);
    for (int i = 0; i < 16; i++) begin
      rd(5'h5, q); chk("rfdata", q, fq.pop_front());
    end
    rd(5'h5, q);
    wt(3);
    rd(5'h4, q); chk("fifocs", q, 16'h0185);
    chk("fifo err", {15'h0, pri_fifo_err_r}, 16'h1);
    $display("fifo done");
    results;
  end
endmodule
